// *** rtl/branch_pkg.sv ***
package branch_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned XLEN      = 32;   // Data and address width
    localparam int unsigned IMM_W     = 16;   // Immediate field width
    localparam int unsigned REG_IDX_W = 5;    // Register index width
    localparam int unsigned OPC_W     = 6;    // Major opcode width
    localparam int unsigned COND_W    = 4;    // Condition field width

    // ----------------------------------------------------------------
    // Field positions (instruction bit 0 is the word's msb, bit 31 here)
    // ----------------------------------------------------------------
    localparam int unsigned FLD_OPC_LSB    = 26;  // Opcode, bits 0..5
    localparam int unsigned FLD_DELAY      = 25;  // Delay flag, bit 6
    localparam int unsigned FLD_COND_LSB   = 21;  // Condition, bits 7..10
    localparam int unsigned FLD_TEST_LSB   = 16;  // Test register, bits 11..15
    localparam int unsigned FLD_IMM_LSB    = 0;   // Immediate, bits 16..31
    localparam int unsigned FLD_OFFSET_LSB = 11;  // Offset register, bits 16..20
    localparam int unsigned FLD_DEST_LSB   = 21;  // Link register, bits 6..10
    localparam int unsigned FLD_J_DELAY    = 20;  // Jump delay flag, bit 11
    localparam int unsigned FLD_J_ABS      = 19;  // Jump absolute flag, bit 12
    localparam int unsigned FLD_J_LINK     = 18;  // Jump link flag, bit 13

    // ----------------------------------------------------------------
    // Opcodes and condition codes
    // ----------------------------------------------------------------
    localparam logic [OPC_W-1:0]  OPC_COND_IMM = 6'h2f;  // Immediate conditional
    localparam logic [OPC_W-1:0]  OPC_COND_REG = 6'h27;  // Register conditional
    localparam logic [OPC_W-1:0]  OPC_JUMP_REG = 6'h26;  // Unconditional register
    localparam logic [COND_W-1:0] COND_NE      = 4'h1;   // Not equal to zero
    localparam logic [COND_W-1:0] COND_LT      = 4'h2;   // Less than zero

    // ----------------------------------------------------------------
    // Sequencing constants
    // ----------------------------------------------------------------
    localparam logic [XLEN-1:0] PC_STEP = 32'h0000_0004;  // Sequential advance

    typedef logic [1:0] cyc_t;                       // Occupancy in cycles
    localparam cyc_t CYC_ZERO        = 2'h0;
    localparam cyc_t CYC_ONE         = 2'h1;
    localparam cyc_t CYC_NOT_TAKEN   = 2'h1;         // Fall-through branch
    localparam cyc_t CYC_TAKEN_DELAY = 2'h2;         // Taken, delay slot kept
    localparam cyc_t CYC_TAKEN_FLUSH = 2'h3;         // Taken, slot discarded

    // Branch class decoded from the word
    typedef enum logic [4:0] {
        KIND_NONE   = 5'b00001,
        KIND_LT_IMM = 5'b00010,
        KIND_NE_REG = 5'b00100,
        KIND_NE_IMM = 5'b01000,
        KIND_JUMP   = 5'b10000
    } kind_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_READY = 2'b01,
        ST_HOLD  = 2'b10
    } state_t;

endpackage

// *** rtl/branch_decode.sv ***
module branch_decode
    import branch_pkg::*;
(
    // Instruction and prefix
    input  wire logic [XLEN-1:0]      instr,
    input  wire logic                 prefix_valid,
    input  wire logic [IMM_W-1:0]     prefix_high,
    // Decoded fields
    output kind_t                     kind,
    output logic                      delay,
    output logic                      absolute,
    output logic                      link,
    output logic                      illegal,
    output logic [REG_IDX_W-1:0]      dest_idx,
    output logic [XLEN-1:0]           imm_operand
);

    logic [OPC_W-1:0]  opc;     // Major opcode
    logic [COND_W-1:0] cond;    // Condition code
    logic [IMM_W-1:0]  imm;     // Raw immediate field

    assign opc      = instr[FLD_OPC_LSB +: OPC_W];
    assign cond     = instr[FLD_COND_LSB +: COND_W];
    assign imm      = instr[FLD_IMM_LSB +: IMM_W];
    assign dest_idx = instr[FLD_DEST_LSB +: REG_IDX_W];

    // ----------------------------------------------------------------
    // Immediate operand: a prefix replaces the sign extension
    // ----------------------------------------------------------------
    always_comb
    begin
        if (prefix_valid)
            imm_operand = {prefix_high, imm};
        else
            imm_operand = {{(XLEN-IMM_W){imm[IMM_W-1]}}, imm};
    end

    // ----------------------------------------------------------------
    // Class and flag decode
    // ----------------------------------------------------------------
    always_comb
    begin
        kind     = KIND_NONE;
        delay    = 1'b0;
        absolute = 1'b0;
        link     = 1'b0;
        illegal  = 1'b0;
        if (opc == OPC_COND_IMM && cond == COND_LT)
        begin
            kind  = KIND_LT_IMM;
            delay = instr[FLD_DELAY];
        end
        else if (opc == OPC_COND_IMM && cond == COND_NE)
        begin
            kind  = KIND_NE_IMM;
            delay = instr[FLD_DELAY];
        end
        else if (opc == OPC_COND_REG && cond == COND_NE)
        begin
            kind  = KIND_NE_REG;
            delay = instr[FLD_DELAY];
        end
        else if (opc == OPC_JUMP_REG)
        begin
            kind     = KIND_JUMP;
            delay    = instr[FLD_J_DELAY];
            absolute = instr[FLD_J_ABS];
            link     = instr[FLD_J_LINK];
            // Link without delay has no valid encoding
            illegal  = instr[FLD_J_LINK] && !instr[FLD_J_DELAY];
        end
    end

endmodule

// *** rtl/branch_resolve.sv ***
module branch_resolve
    import branch_pkg::*;
(
    // Decoded branch
    input  kind_t                     kind,
    input  wire logic                 absolute,
    // Operands
    input  wire logic [XLEN-1:0]      pc,
    input  wire logic [XLEN-1:0]      test_value,
    input  wire logic [XLEN-1:0]      offset_value,
    input  wire logic [XLEN-1:0]      imm_operand,
    // Result
    output logic                      taken,
    output logic [XLEN-1:0]           next_pc
);

    // ----------------------------------------------------------------
    // Condition and target selection
    // ----------------------------------------------------------------
    always_comb
    begin
        taken   = 1'b0;
        next_pc = pc + PC_STEP;
        unique case (kind)
            KIND_LT_IMM:
            begin
                // Two's complement: negative means msb set
                taken = test_value[XLEN-1];
                if (taken)
                    next_pc = pc + imm_operand;
            end
            KIND_NE_IMM:
            begin
                taken = |test_value;
                if (taken)
                    next_pc = pc + imm_operand;
            end
            KIND_NE_REG:
            begin
                taken = |test_value;
                if (taken)
                    next_pc = pc + offset_value;
            end
            KIND_JUMP:
            begin
                taken   = 1'b1;
                next_pc = absolute ? offset_value : pc + offset_value;
            end
            KIND_NONE:
            begin
                taken = 1'b0;
            end
        endcase
    end

endmodule

// *** rtl/branch_execute_unit.sv ***
module branch_execute_unit
    import branch_pkg::*;
(
    // Clock and reset
    input  wire logic                      MCLK,
    input  wire logic                      RST_N,
    // Instruction from the decode stage
    input  wire logic                      INSTR_VALID,
    input  wire logic [XLEN-1:0]           INSTR,
    input  wire logic [XLEN-1:0]           INSTR_PC,
    // Immediate prefix from the instruction just before
    input  wire logic                      PREFIX_VALID,
    input  wire logic [IMM_W-1:0]          PREFIX_HIGH,
    // Register file operands
    input  wire logic [XLEN-1:0]           TEST_SOURCE_REG,
    input  wire logic [XLEN-1:0]           OFFSET_SOURCE_REG,
    // Pipeline control
    output logic                           READY,
    output logic                           PC_LOAD,
    output logic [XLEN-1:0]                NEXT_PC,
    output logic                           TAKEN,
    output logic                           FLUSH,
    output logic                           SLOT_KEEP,
    output logic                           ILLEGAL,
    // Link write to the register file
    output logic                           LINK_WE,
    output logic [REG_IDX_W-1:0]           LINK_REG,
    output logic [XLEN-1:0]                LINK_DATA
);

    import branch_pkg::*;

    // ----------------------------------------------------------------
    // Timing summary
    // ----------------------------------------------------------------
    // Edge 0 takes the word; every result pulse stands in the cycle
    // after it. An untaken branch leaves READY high, so a new word may
    // follow on edge 1. A taken delayed branch drops READY for one
    // cycle, a taken undelayed one for two, which gives the pipeline
    // room to fetch the target. The stall is counted here rather than
    // in the fetch stage, so that stage needs no knowledge of the
    // delay flag. Reserved jump encodings are reported, never executed.

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    kind_t                 kind;          // Decoded branch class
    logic                  delay;         // Delay slot requested
    logic                  absolute;      // Target is the register itself
    logic                  link;          // Return address wanted
    logic                  illegal;       // Reserved jump encoding
    logic [REG_IDX_W-1:0]  dest_idx;      // Link destination index
    logic [XLEN-1:0]       imm_operand;   // Extended or prefixed immediate
    logic                  taken;         // Condition met
    logic [XLEN-1:0]       target_pc;     // Resolved next program counter

    logic                  accept;        // Word taken this cycle
    logic                  is_branch;     // Accepted word is a valid branch
    cyc_t                  next_cycles;   // Occupancy of the accepted branch
    logic                  multi_cycle;   // Branch needs extra cycles

    state_t                state;         // Sequencer state
    cyc_t                  remaining;     // Extra cycles still to hold

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    branch_decode branch_decode_i (
        .instr        (INSTR),
        .prefix_valid (PREFIX_VALID),
        .prefix_high  (PREFIX_HIGH),
        .kind         (kind),
        .delay        (delay),
        .absolute     (absolute),
        .link         (link),
        .illegal      (illegal),
        .dest_idx     (dest_idx),
        .imm_operand  (imm_operand)
    );

    // ----------------------------------------------------------------
    // Condition test and target arithmetic
    // ----------------------------------------------------------------
    branch_resolve branch_resolve_i (
        .kind         (kind),
        .absolute     (absolute),
        .pc           (INSTR_PC),
        .test_value   (TEST_SOURCE_REG),
        .offset_value (OFFSET_SOURCE_REG),
        .imm_operand  (imm_operand),
        .taken        (taken),
        .next_pc      (target_pc)
    );

    // ----------------------------------------------------------------
    // Acceptance
    // ----------------------------------------------------------------
    // A word is only taken while the sequencer is idle; READY is the
    // registered copy of that, so the stage above sees a clean level
    assign accept    = INSTR_VALID && READY;
    // Reserved encodings never steer the PC
    assign is_branch = (kind != KIND_NONE) && !illegal;

    // ----------------------------------------------------------------
    // Occupancy of the accepted branch
    // ----------------------------------------------------------------
    always_comb
    begin
        if (!taken)
            next_cycles = CYC_NOT_TAKEN;
        else if (delay)
            next_cycles = CYC_TAKEN_DELAY;
        else
            next_cycles = CYC_TAKEN_FLUSH;
    end

    assign multi_cycle = next_cycles > CYC_NOT_TAKEN;

    // ----------------------------------------------------------------
    // Sequencer: holds the stage for the extra cycles
    // ----------------------------------------------------------------
    // The count is loaded with cycles minus one, since the accept
    // cycle itself is the first cycle of the branch
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state     <= ST_READY;
            remaining <= CYC_ZERO;
        end
        else
        begin
            unique case (state)
                ST_READY:
                begin
                    // Start holding only for a taken branch
                    if (accept && is_branch && multi_cycle)
                    begin
                        state     <= ST_HOLD;
                        remaining <= next_cycles - CYC_ONE;
                    end
                end
                ST_HOLD:
                begin
                    // Release when the last extra cycle ends
                    if (remaining == CYC_ONE)
                        state <= ST_READY;
                    remaining <= remaining - CYC_ONE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Ready flag toward the decode stage
    // ----------------------------------------------------------------
    // Kept as its own flop so that the output does not depend on the
    // state decode; it drops on the accept edge of a taken branch
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            READY <= 1'b1;
        else if (state == ST_READY && accept && is_branch && multi_cycle)
            READY <= 1'b0;
        else if (state == ST_HOLD && remaining == CYC_ONE)
            READY <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Program counter update
    // ----------------------------------------------------------------
    // Load strobe: one pulse for every accepted valid branch, taken or not
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            PC_LOAD <= 1'b0;
        else
            PC_LOAD <= accept && is_branch;
    end

    // Taken flag rides with the load strobe, never on its own
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            TAKEN <= 1'b0;
        else
            TAKEN <= accept && is_branch && taken;
    end

    // NEXT_PC holds its value between loads; the fetch stage only
    // looks at it when PC_LOAD pulses
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            NEXT_PC <= '0;
        else if (accept && is_branch)
            NEXT_PC <= target_pc;
    end

    // ----------------------------------------------------------------
    // Delay slot handling
    // ----------------------------------------------------------------
    // Without a delay slot the word already fetched behind the branch
    // must die; with one it runs to completion before the target
    // Kill strobe for the sequential word of a taken undelayed branch
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            FLUSH <= 1'b0;
        else
            FLUSH <= accept && is_branch && taken && !delay;
    end

    // Keep strobe: the sequential word is a delay slot and completes
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            SLOT_KEEP <= 1'b0;
        else
            SLOT_KEEP <= accept && is_branch && taken && delay;
    end

    // ----------------------------------------------------------------
    // Reserved encoding report
    // ----------------------------------------------------------------
    // The word is consumed in one cycle and leaves the PC alone, so the
    // pipeline can raise its own exception from this pulse
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            ILLEGAL <= 1'b0;
        else
            ILLEGAL <= accept && (kind == KIND_JUMP) && illegal;
    end

    // ----------------------------------------------------------------
    // Link write
    // ----------------------------------------------------------------
    // The return value is the branch's own address, not the address
    // after the delay slot; software adds the step itself on return
    // Write strobe toward the register file, one cycle wide
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            LINK_WE <= 1'b0;
        else
            LINK_WE <= accept && is_branch && (kind == KIND_JUMP) && link;
    end

    // Index and value hold until the next link, so a slow register
    // file may still read them after the strobe has gone
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            LINK_REG  <= '0;
            LINK_DATA <= '0;
        end
        else if (accept && is_branch && (kind == KIND_JUMP) && link)
        begin
            LINK_REG  <= dest_idx;
            LINK_DATA <= INSTR_PC;
        end
    end

endmodule

// *** verif/branch_execute_unit_props.sv ***
module branch_execute_unit_checker
(
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST_N,
    // Instruction side
    input wire logic        INSTR_VALID,
    input wire logic [31:0] INSTR,
    input wire logic [31:0] INSTR_PC,
    input wire logic        PREFIX_VALID,
    input wire logic [15:0] PREFIX_HIGH,
    input wire logic [31:0] TEST_SOURCE_REG,
    input wire logic [31:0] OFFSET_SOURCE_REG,
    // Pipeline control and link
    input wire logic        READY,
    input wire logic        PC_LOAD,
    input wire logic [31:0] NEXT_PC,
    input wire logic        TAKEN,
    input wire logic        FLUSH,
    input wire logic        SLOT_KEEP,
    input wire logic        ILLEGAL,
    input wire logic        LINK_WE,
    input wire logic [4:0]  LINK_REG,
    input wire logic [31:0] LINK_DATA
);
    timeunit 1ns;
    timeprecision 1ps;
    import branch_pkg::*;

    // Accepted word and its class; other condition codes are not branches
    logic acc, ci_lt, ci_ne, cr_ne, jmp;
    assign acc   = INSTR_VALID && READY;
    assign ci_lt = acc && INSTR[31:26] == OPC_COND_IMM && INSTR[24:21] == COND_LT;
    assign ci_ne = acc && INSTR[31:26] == OPC_COND_IMM && INSTR[24:21] == COND_NE;
    assign cr_ne = acc && INSTR[31:26] == OPC_COND_REG && INSTR[24:21] == COND_NE;
    assign jmp   = acc && INSTR[31:26] == OPC_JUMP_REG;

    // One domain, so clock and reset are given once
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    AST_STEP_FOUR: assert property (acc ##1 (PC_LOAD && !TAKEN) |-> READY && NEXT_PC == $past(INSTR_PC) + PC_STEP)
        else $error("Untaken step wrong");
    AST_DELAY_TWO: assert property (PC_LOAD && SLOT_KEEP |-> !READY ##1 READY)
        else $error("Delayed occupancy wrong");
    AST_FLUSH_THREE: assert property (PC_LOAD && FLUSH |-> !READY [*2] ##1 READY)
        else $error("Undelayed occupancy wrong");
    AST_LT_TARGET: assert property (ci_lt && !PREFIX_VALID |=> PC_LOAD && TAKEN == $past(TEST_SOURCE_REG[31])
        && (!TAKEN || SLOT_KEEP == $past(INSTR[25]) && NEXT_PC == $past(INSTR_PC) + {{16{$past(INSTR[15])}}, $past(INSTR[15:0])}))
        else $error("Less-than target wrong");
    AST_PREFIX_OPERAND: assert property (ci_ne && PREFIX_VALID |=> PC_LOAD
        && (!TAKEN || NEXT_PC == $past(INSTR_PC) + {$past(PREFIX_HIGH), $past(INSTR[15:0])}))
        else $error("Prefixed target wrong");
    AST_NE_REG_TARGET: assert property (cr_ne |=> PC_LOAD && TAKEN == ($past(TEST_SOURCE_REG) != 0)
        && (!TAKEN || SLOT_KEEP == $past(INSTR[25]) && NEXT_PC == $past(INSTR_PC) + $past(OFFSET_SOURCE_REG)))
        else $error("Not-equal target wrong");
    AST_JUMP_TARGET: assert property (jmp && (INSTR[20] || !INSTR[18]) |=> PC_LOAD && TAKEN
        && SLOT_KEEP == $past(INSTR[20]) && LINK_WE == $past(INSTR[18]) && (!LINK_WE || LINK_DATA == $past(INSTR_PC))
        && NEXT_PC == ($past(INSTR[19]) ? $past(OFFSET_SOURCE_REG) : $past(INSTR_PC) + $past(OFFSET_SOURCE_REG)))
        else $error("Jump result wrong");
    AST_ILLEGAL_JUMP: assert property (jmp && INSTR[18] && !INSTR[20] |=> ILLEGAL && !PC_LOAD && !LINK_WE && READY)
        else $error("Link without delay not refused");
endmodule

bind branch_execute_unit branch_execute_unit_checker branch_execute_unit_checker_i (
    .MCLK(MCLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .INSTR_PC(INSTR_PC),
    .PREFIX_VALID(PREFIX_VALID), .PREFIX_HIGH(PREFIX_HIGH), .TEST_SOURCE_REG(TEST_SOURCE_REG),
    .OFFSET_SOURCE_REG(OFFSET_SOURCE_REG), .READY(READY), .PC_LOAD(PC_LOAD), .NEXT_PC(NEXT_PC), .TAKEN(TAKEN),
    .FLUSH(FLUSH), .SLOT_KEEP(SLOT_KEEP), .ILLEGAL(ILLEGAL), .LINK_WE(LINK_WE), .LINK_REG(LINK_REG),
    .LINK_DATA(LINK_DATA)
);

// *** verif/test_branch_execute_unit.sv ***
module test_branch_execute_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import branch_pkg::*;

    // Stimulus and observed outputs
    logic                 mclk, rst_n, instr_valid, prefix_valid;
    logic [XLEN-1:0]      instr, instr_pc, test_source_reg, offset_source_reg, next_pc, link_data;
    logic [IMM_W-1:0]     prefix_high;
    logic                 ready, pc_load, taken, flush, slot_keep, illegal, link_we;
    logic [REG_IDX_W-1:0] link_reg;
    int                   miscompares, samples_checked;

    branch_execute_unit branch_execute_unit_i (
        .MCLK(mclk), .RST_N(rst_n), .INSTR_VALID(instr_valid), .INSTR(instr), .INSTR_PC(instr_pc),
        .PREFIX_VALID(prefix_valid), .PREFIX_HIGH(prefix_high), .TEST_SOURCE_REG(test_source_reg),
        .OFFSET_SOURCE_REG(offset_source_reg), .READY(ready), .PC_LOAD(pc_load), .NEXT_PC(next_pc),
        .TAKEN(taken), .FLUSH(flush), .SLOT_KEEP(slot_keep), .ILLEGAL(illegal), .LINK_WE(link_we),
        .LINK_REG(link_reg), .LINK_DATA(link_data)
    );

    // 40 MHz core clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Verdict; the only place the run ends
    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Case-equality compare, so an unknown never matches
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Word builders: immediate conditional, register not-equal, register jump
    function automatic logic [31:0] ci(input logic d, input logic [3:0] c, input logic [15:0] imm);
        return {OPC_COND_IMM, d, c, 5'h03, imm};
    endfunction
    function automatic logic [31:0] cr(input logic d);
        return {OPC_COND_REG, d, COND_NE, 5'h03, 5'h04, 11'h000};
    endfunction
    function automatic logic [31:0] jr(input logic d, input logic a, input logic l, input logic [4:0] rd);
        return {OPC_JUMP_REG, rd, d, a, l, 2'h0, 5'h04, 11'h000};
    endfunction

    // Issue one word, judge the pulses {load,taken,flush,keep,illegal,link}, then the occupancy
    task automatic op(input logic [31:0] ins, pc, tv, ov, input logic [5:0] ep, input logic [31:0] epc, input cyc_t occ);
        int n;
        @(posedge mclk);
        #1;
        {instr_valid, instr, instr_pc, test_source_reg, offset_source_reg} = {1'b1, ins, pc, tv, ov};
        @(posedge mclk);
        #1;
        instr_valid = 1'b0;
        prefix_valid = 1'b0;
        check(32'({pc_load, taken, flush, slot_keep, illegal, link_we}), 32'(ep));
        if (ep[5])
            check(next_pc, epc);
        if (ep[0])
            check(link_data, pc);
        if (ep[0])
            check(32'(link_reg), 32'(ins[25:21]));
        n = 1;
        // Bounded wait for the next accept; a stuck READY ends the run
        while (ready !== 1'b1 && n < 8)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(32'(n), 32'(occ));
        if (n >= 8)
            conclude();
    endtask

    // Less-than: negative sign-extended offset, msb boundary
    task automatic test_lt_imm();
        op(ci(1'b0, COND_LT, 16'hfff0), 32'h1000, 32'h8000_0000, 32'h0, 6'h38, 32'h0ff0, CYC_TAKEN_FLUSH);
        op(ci(1'b1, COND_LT, 16'h0040), 32'h2000, 32'hffff_ffff, 32'h0, 6'h34, 32'h2040, CYC_TAKEN_DELAY);
        op(ci(1'b1, COND_LT, 16'h0040), 32'h2000, 32'h7fff_ffff, 32'h0, 6'h20, 32'h2004, CYC_NOT_TAKEN);
    endtask

    // Register not-equal: lowest bit alone is nonzero
    task automatic test_ne_reg();
        op(cr(1'b0), 32'h3000, 32'h1, 32'hffff_ff00, 6'h38, 32'h2f00, CYC_TAKEN_FLUSH);
        op(cr(1'b1), 32'h3000, 32'h8000_0000, 32'h100, 6'h34, 32'h3100, CYC_TAKEN_DELAY);
        op(cr(1'b1), 32'h3000, 32'h0, 32'h100, 6'h20, 32'h3004, CYC_NOT_TAKEN);
    endtask

    // Immediate not-equal, with and without a prefix
    task automatic test_ne_imm();
        prefix_valid = 1'b1;
        prefix_high = 16'h0001;
        op(ci(1'b0, COND_NE, 16'h8000), 32'h100, 32'h2, 32'h0, 6'h38, 32'h0001_8100, CYC_TAKEN_FLUSH);
        op(ci(1'b1, COND_NE, 16'h8000), 32'h100, 32'h2, 32'h0, 6'h34, 32'hffff_8100, CYC_TAKEN_DELAY);
        op(ci(1'b0, COND_NE, 16'h7fff), 32'h100, 32'h0, 32'h0, 6'h20, 32'h0104, CYC_NOT_TAKEN);
    endtask

    // Every flag combination; link without delay must be refused
    task automatic test_jump();
        logic       d, a, l;
        logic [5:0] ep;
        cyc_t       occ;
        for (int k = 0; k < 8; k++)
        begin
            {d, a, l} = 3'(k);
            ep = (l && !d) ? 6'h02 : {2'b11, !d, d, 1'b0, l};
            occ = (l && !d) ? CYC_ONE : (d ? CYC_TAKEN_DELAY : CYC_TAKEN_FLUSH);
            op(jr(d, a, l, 5'(k + 3)), 32'h4000 + 32'(k), 32'h0, 32'h0001_0000, ep,
               a ? 32'h0001_0000 : 32'h0001_4000 + 32'(k), occ);
        end
    endtask

    // Back-to-back untaken words, then a word held through a flush stall
    task automatic test_refused();
        @(posedge mclk);
        #1;
        {instr_valid, instr, instr_pc, test_source_reg} = {1'b1, cr(1'b0), 32'h40, 32'h0};
        @(posedge mclk);
        #1;
        check(next_pc, 32'h44);
        instr_pc = 32'h80;
        @(posedge mclk);
        #1;
        check(next_pc, 32'h84);
        {instr, instr_pc, test_source_reg} = {ci(1'b0, COND_LT, 16'h0010), 32'h100, 32'h8000_0000};
        @(posedge mclk);
        #1;
        check(next_pc, 32'h110);
        {instr_pc, test_source_reg} = {32'h200, 32'h0};
        repeat (2)
        begin
            @(posedge mclk);
            #1;
            check(32'(pc_load), 32'h0);
        end
        @(posedge mclk);
        #1;
        instr_valid = 1'b0;
        check(next_pc, 32'h204);
    endtask

    // Main sequence
    initial
    begin
        {rst_n, instr_valid, prefix_valid, prefix_high} = '0;
        {instr, instr_pc, test_source_reg, offset_source_reg} = '0;
        miscompares = 0;
        samples_checked = 0;
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        check(32'(ready), 32'h1);
        check(next_pc, 32'h0);
        test_lt_imm();
        test_ne_reg();
        test_ne_imm();
        test_jump();
        test_refused();
        conclude();
    end
endmodule
